// ### tdl_params.svh
`ifndef TDL_PARAMS_SVH
`define TDL_PARAMS_SVH

// elastic store between rail sampling and line driver
`define TDL_FIFO_DEPTH 16
// bits per stored line symbol
`define TDL_SYM_WIDTH 2
// reset value of the alternate-mark polarity in single-rail mode
`define TDL_AMI_RESET 1'b0
// reset value of the line driver levels
`define TDL_LEVEL_RESET 1'b0
// reset value of an active-low output enable (released)
`define TDL_OE_N_RESET 1'b1

`endif

// ### tdl_pkg.sv
`include "tdl_params.svh"

package tdl_pkg;
    // one transmitted bit period on the line
    typedef enum logic [`TDL_SYM_WIDTH-1:0] {
        TDL_SYM_ZERO = 2'h0,
        TDL_SYM_POS = 2'h1,
        TDL_SYM_NEG = 2'h2
    } tdl_sym_t;
endpackage

// ### tdl_fifo.sv
`timescale 1ns/1ps

module tdl_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;
    logic [AW-1:0] next_rd_ptr;

    assign in_ready = (count != FULL_COUNT);
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign next_rd_ptr = (rd_ptr == LAST_IDX) ? '0 : rd_ptr + AW'(1);

    // storage array has no reset; only written words are ever read
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == LAST_IDX) ? '0 : wr_ptr + AW'(1);
            end
            if (pop)
            begin
                rd_ptr <= next_rd_ptr;
            end
            if (push && !pop)
            begin
                count <= count + (AW+1)'(1);
            end
            else if (pop && !push)
            begin
                count <= count - (AW+1)'(1);
            end
        end
    end

    // head word held in a register so the reader sees a flop
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            out_data <= '0;
        end
        else if (push && (count == '0 || (pop && count == (AW+1)'(1))))
        begin
            out_data <= in_data;
        end
        else if (pop && count > (AW+1)'(1))
        begin
            out_data <= mem[next_rd_ptr];
        end
    end
endmodule

// ### tdl_tx.sv
`timescale 1ns/1ps
`include "tdl_params.svh"

// How it works
// - The negative rail is captured on the rising edge of the channel transmit clock.
// - In single-rail mode the negative rail is ignored, whatever level the framer holds it at.
// - A positive pulse drives the plus line high and the minus line low.
// - A negative pulse drives the plus line low and the minus line high.
// - Both line outputs float whenever the enable pin or the enable control bit is low.
// - The enable pin low switches the transmitter off; high lets the control bit decide.
// - Dual-rail data go to the line as given, with no zero-substitution coding.
module tdl_tx #(
    parameter int FIFO_DEPTH = `TDL_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // framer side, asynchronous pins
    input wire logic transmit_clock_in,
    input wire logic tx_positive_rail,
    input wire logic tx_negative_rail,
    input wire logic dual_rail_mode,
    // transmitter enable, pin and channel control bit
    input wire logic transmit_on,
    input wire logic transmit_on_bit,
    // line driver pair, enables active low
    output logic line_out_plus,
    output logic line_out_plus_oe_n,
    output logic line_out_minus,
    output logic line_out_minus_oe_n,
    // status
    output logic tx_overrun
);
    import tdl_pkg::*;

    logic [2:0] clk_sync;
    logic [1:0] pos_sync;
    logic [1:0] neg_sync;
    logic [1:0] mode_sync;
    logic [1:0] on_pin_sync;
    logic [1:0] on_bit_sync;
    logic bit_edge;
    logic dual;
    logic tx_enabled;
    logic ami_pol;
    tdl_sym_t push_sym;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [`TDL_SYM_WIDTH-1:0] fifo_out_data;
    logic pop;
    tdl_sym_t head_sym;

    // two flops on every pin; the third clock flop only feeds edge detection
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            clk_sync <= 3'h0;
            pos_sync <= 2'h0;
            neg_sync <= 2'h0;
            mode_sync <= 2'h0;
            on_pin_sync <= 2'h0;
            on_bit_sync <= 2'h0;
        end
        else
        begin
            clk_sync <= {clk_sync[1:0], transmit_clock_in};
            pos_sync <= {pos_sync[0], tx_positive_rail};
            neg_sync <= {neg_sync[0], tx_negative_rail};
            mode_sync <= {mode_sync[0], dual_rail_mode};
            on_pin_sync <= {on_pin_sync[0], transmit_on};
            on_bit_sync <= {on_bit_sync[0], transmit_on_bit};
        end
    end

    // active edge of the transmit clock marks one bit period
    assign bit_edge = clk_sync[1] && !clk_sync[2];
    assign dual = mode_sync[1];
    // pin low overrides every channel setting
    assign tx_enabled = on_pin_sync[1] && on_bit_sync[1];

    // symbol for this bit period
    always_comb
    begin
        push_sym = TDL_SYM_ZERO;
        if (dual)
        begin
            // rails taken verbatim; both high at once is illegal and sends nothing
            if (pos_sync[1] && !neg_sync[1])
            begin
                push_sym = TDL_SYM_POS;
            end
            else if (neg_sync[1] && !pos_sync[1])
            begin
                push_sym = TDL_SYM_NEG;
            end
        end
        else if (pos_sync[1])
        begin
            // negative rail never read here; marks alternate polarity
            push_sym = ami_pol ? TDL_SYM_NEG : TDL_SYM_POS;
        end
    end

    // mark polarity for single-rail data, only flips on an accepted mark
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ami_pol <= `TDL_AMI_RESET;
        end
        else if (bit_edge && fifo_in_ready && !dual && pos_sync[1])
        begin
            ami_pol <= !ami_pol;
        end
    end

    // overrun: a bit period arrived while the store was full and it was lost
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            tx_overrun <= 1'b0;
        end
        else
        begin
            tx_overrun <= bit_edge && !fifo_in_ready;
        end
    end

    // draining stalls while the driver is off, so the store really fills
    assign pop = bit_edge && tx_enabled && fifo_out_valid;
    assign head_sym = tdl_sym_t'(fifo_out_data);

    tdl_fifo #(
        .WIDTH(`TDL_SYM_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_store (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(bit_edge),
        .in_data(push_sym),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(bit_edge && tx_enabled)
    );

    // line levels, updated once per bit period
    always_ff @(posedge clock)
    begin
        if (sys_rst || !tx_enabled)
        begin
            line_out_plus <= `TDL_LEVEL_RESET;
            line_out_minus <= `TDL_LEVEL_RESET;
        end
        else if (pop)
        begin
            line_out_plus <= (head_sym == TDL_SYM_POS);
            line_out_minus <= (head_sym == TDL_SYM_NEG);
        end
        else if (bit_edge)
        begin
            // underflow sends a space rather than repeating a pulse
            line_out_plus <= 1'b0;
            line_out_minus <= 1'b0;
        end
    end

    // driver enables; released lines float toward the transformer
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            line_out_plus_oe_n <= `TDL_OE_N_RESET;
            line_out_minus_oe_n <= `TDL_OE_N_RESET;
        end
        else
        begin
            line_out_plus_oe_n <= !tx_enabled;
            line_out_minus_oe_n <= !tx_enabled;
        end
    end

    // named sequences for the drive checks
    sequence s_pos_pop;
        pop && head_sym == TDL_SYM_POS;
    endsequence

    sequence s_neg_pop;
        pop && head_sym == TDL_SYM_NEG;
    endsequence

    chk_pos_drive: assert property (@(posedge clock) disable iff (sys_rst)
        s_pos_pop |=> line_out_plus && !line_out_minus && !line_out_plus_oe_n)
        else $error("positive pulse not driven plus over minus");

    chk_neg_drive: assert property (@(posedge clock) disable iff (sys_rst)
        s_neg_pop |=> !line_out_plus && line_out_minus && !line_out_minus_oe_n)
        else $error("negative pulse not driven minus over plus");

    chk_off_float: assert property (@(posedge clock) disable iff (sys_rst)
        !tx_enabled |=> line_out_plus_oe_n && line_out_minus_oe_n
            && !line_out_plus && !line_out_minus)
        else $error("line not floated while transmitter off");

    chk_pin_off: assert property (@(posedge clock) disable iff (sys_rst)
        !on_pin_sync[1] [*2] |=> line_out_plus_oe_n && line_out_minus_oe_n)
        else $error("enable pin low did not switch transmitter off");

    chk_on_drive: assert property (@(posedge clock) disable iff (sys_rst)
        tx_enabled |=> !line_out_plus_oe_n && !line_out_minus_oe_n)
        else $error("transmitter enabled but line not driven");

    chk_neg_sample: assert property (@(posedge clock) disable iff (sys_rst)
        bit_edge && dual && neg_sync[1] && !pos_sync[1] |-> push_sym == TDL_SYM_NEG)
        else $error("negative rail not captured on clock edge");

    chk_single_ignore: assert property (@(posedge clock) disable iff (sys_rst)
        !dual && !pos_sync[1] |-> push_sym == TDL_SYM_ZERO)
        else $error("negative rail acted on in single-rail mode");

    chk_dual_plain: assert property (@(posedge clock) disable iff (sys_rst)
        dual && pos_sync[1] && !neg_sync[1] && $past(pos_sync[1]) |-> push_sym == TDL_SYM_POS)
        else $error("dual-rail data recoded");

    chk_space_zero: assert property (@(posedge clock) disable iff (sys_rst)
        tx_enabled && bit_edge && !fifo_out_valid |=> line_out_plus == line_out_minus)
        else $error("pulse sent in an empty bit period");
endmodule

// ### tdl_framer_model.sv
`timescale 1ns/1ps

// framer stand-in: one bit every 8 clocks, rails settle 3 clocks before the rise
module tdl_framer_model (
    // system clock
    input wire logic clock,
    // bit supply from the bench
    input wire logic run,
    input wire logic next_pos,
    input wire logic next_neg,
    output logic load,
    // pins toward the channel
    output logic transmit_clock_in = 1'b0,
    output logic tx_positive_rail = 1'b0,
    output logic tx_negative_rail = 1'b0
);
    logic [2:0] cnt = 3'h0;

    assign load = run && cnt == 3'h0;

    // transmit clock high for cnt 4..7, stands low while idle
    always_ff @(posedge clock)
    begin
        cnt <= run ? cnt + 3'h1 : 3'h0;
        transmit_clock_in <= run && cnt >= 3'h3 && cnt != 3'h7;
    end

    // idle rails toggle so stale data never passes as a held bit
    always_ff @(posedge clock)
    begin
        if (!run)
            {tx_positive_rail, tx_negative_rail} <= ~{tx_positive_rail, tx_negative_rail};
        else if (cnt == 3'h0)
            {tx_positive_rail, tx_negative_rail} <= {next_pos, next_neg};
    end
endmodule

// ### tdl_tx_tb.sv
`timescale 1ns/1ps

module tdl_tx_tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic dual_rail_mode = 1'b1;
    logic transmit_on = 1'b1;
    logic transmit_on_bit = 1'b1;
    logic run = 1'b0;
    logic next_pos = 1'b0;
    logic next_neg = 1'b0;
    logic load, transmit_clock_in, tx_positive_rail, tx_negative_rail;
    logic line_out_plus, line_out_plus_oe_n, line_out_minus, line_out_minus_oe_n, tx_overrun;
    logic [3:0] line_word;
    logic t_prev = 1'b0;
    int mcnt = 0;
    int n_ovr = 0;
    int n_errors = 0;
    int n_compared = 0;
    logic [3:0] got [$];
    logic [1:0] seq_rail [$];
    logic [3:0] seq_exp [$];

    // 100 MHz system clock
    initial
    begin
        forever #5 clock = ~clock;
    end

    tdl_framer_model tdl_framer_model_inst (.clock(clock), .run(run), .next_pos(next_pos),
        .next_neg(next_neg), .load(load), .transmit_clock_in(transmit_clock_in),
        .tx_positive_rail(tx_positive_rail), .tx_negative_rail(tx_negative_rail));

    tdl_tx tdl_tx_inst (.clock(clock), .sys_rst(sys_rst), .transmit_clock_in(transmit_clock_in),
        .tx_positive_rail(tx_positive_rail), .tx_negative_rail(tx_negative_rail),
        .dual_rail_mode(dual_rail_mode), .transmit_on(transmit_on),
        .transmit_on_bit(transmit_on_bit), .line_out_plus(line_out_plus),
        .line_out_plus_oe_n(line_out_plus_oe_n), .line_out_minus(line_out_minus),
        .line_out_minus_oe_n(line_out_minus_oe_n), .tx_overrun(tx_overrun));

    // enables and levels packed as one line symbol for comparison
    assign line_word = {line_out_plus_oe_n, line_out_minus_oe_n, line_out_plus, line_out_minus};

    // sample the line 7 clocks after each transmit clock rise, mid bit period
    always @(posedge clock)
    begin
        t_prev <= transmit_clock_in;
        if (tx_overrun === 1'b1)
            n_ovr <= n_ovr + 1;
        if (transmit_clock_in && !t_prev)
            mcnt <= 6;
        else if (mcnt > 0)
        begin
            mcnt <= mcnt - 1;
            if (mcnt == 1)
                got.push_back(line_word);
        end
    end

    task conclude;
        if (n_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task fail(input string msg);
        n_errors++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    task tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // offer one bit and wait until the framer takes it
    task feed(input logic [1:0] r);
        int i;
        {next_pos, next_neg} = r;
        run = 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge clock);
            if (load === 1'b1)
                break;
        end
        if (i == 20)
        begin
            fail("framer never took a bit");
            conclude();
        end
        else
        begin
            #1;
        end
    endtask

    // sample k+1 carries bit k, since the store adds one bit period
    task run_seq;
        got.delete();
        foreach (seq_rail[k])
            feed(seq_rail[k]);
        repeat (3) feed(2'h0);
        run = 1'b0;
        tick(10);
        foreach (seq_exp[k])
        begin
            n_compared++;
            if (got.size() < k + 2 || got[k + 1] !== seq_exp[k])
                fail("line symbol");
        end
    endtask

    task do_reset;
        sys_rst = 1'b1;
        tick(3);
        sys_rst = 1'b0;
        tick(4);
    endtask

    // four zeros in a row stay zeros: no substitution
    task dual_rail_check;
        int base;
        base = n_ovr;
        seq_rail = '{2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h2, 2'h1, 2'h1};
        seq_exp = '{4'h2, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h2, 4'h1, 4'h1};
        run_seq();
        n_compared++;
        if (n_ovr != base)
            fail("overrun without a full store");
    endtask

    // negative rail held high on purpose: it must be ignored
    task single_rail_check;
        dual_rail_mode = 1'b0;
        do_reset();
        seq_rail = '{2'h3, 2'h1, 2'h1, 2'h1, 2'h3, 2'h3, 2'h3};
        seq_exp = '{4'h2, 4'h0, 4'h0, 4'h0, 4'h1, 4'h2, 4'h1};
        run_seq();
    endtask

    task enable_check;
        transmit_on = 1'b0;
        tick(5);
        n_compared++;
        if (line_word !== 4'hC)
            fail("pin off but line driven");
        transmit_on = 1'b1;
        tick(5);
        n_compared++;
        if (line_word[3:2] !== 2'h0)
            fail("line not driven when on");
        transmit_on_bit = 1'b0;
        tick(5);
        n_compared++;
        if (line_word !== 4'hC)
            fail("control bit off but line driven");
        transmit_on_bit = 1'b1;
    endtask

    // off: the 16-word store fills, two of 18 bits are lost
    task overrun_check;
        int base;
        transmit_on = 1'b0;
        do_reset();
        base = n_ovr;
        seq_exp.delete();
        seq_rail.delete();
        repeat (16) seq_rail.push_back(2'h2);
        run_seq();
        n_compared++;
        if (n_ovr - base != 2)
            fail("overrun count");
        foreach (got[k])
        begin
            n_compared++;
            if (got[k] !== 4'hC)
                fail("line driven while off");
        end
        transmit_on = 1'b1;
    endtask

    initial
    begin
        tick(16);
        sys_rst = 1'b0;
        tick(4);
        dual_rail_check();
        single_rail_check();
        enable_check();
        overrun_check();
        conclude();
    end
endmodule
